// file: hw/bus_matrix.sv
// Five-master, five-slave bus matrix with decode, arbitration and boot remap.
`timescale 1ns/1ps
`default_nettype none
module bus_matrix
  import matrix_pkg::*;
#(
  parameter int NM = NUM_MASTERS,
  parameter int NS = NUM_SLAVES
) (
  // Clock and reset
  input  wire logic            CLK_I,
  input  wire logic            RSTN_I,
  // Boot, remap and arbitration control
  input  wire logic            BOOT_SELECT_PIN_I,
  input  wire logic [NM-1:0]   REMAP_SET_I,
  input  wire logic [NS*2-1:0] DEF_MODE_I,
  input  wire logic [NS*3-1:0] DEF_MASTER_I,
  input  wire logic [NS*8-1:0] SLOT_LIMIT_I,
  // Master side
  input  wire logic [NM-1:0]   M_REQ_I,
  input  wire logic [NM*32-1:0] M_ADDR_I,
  input  wire logic [NM*2-1:0] M_SIZE_I,
  input  wire logic [NM-1:0]   M_WRITE_I,
  input  wire logic [NM*32-1:0] M_WDATA_I,
  output logic      [NM-1:0]   M_GNT_O,
  output logic      [NM-1:0]   M_ABORT_O,
  output logic      [NM*32-1:0] M_RDATA_O,
  // Slave side
  output logic      [NS-1:0]   S_SEL_O,
  output logic      [NS*32-1:0] S_ADDR_O,
  output logic      [NS*2-1:0] S_SIZE_O,
  output logic      [NS-1:0]   S_WRITE_O,
  output logic      [NS*32-1:0] S_WDATA_O,
  input  wire logic [NS*32-1:0] S_RDATA_I,
  // External chip selects and boot setup
  output logic      [7:0]      EXT_CS_N_O,
  output logic                 BOOT_SLOW_CLK_O,
  output logic                 BOOT_BUS16_O
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic              boot_sel;
    logic [NM-1:0]     remap;
    logic [NS-1:0][2:0] owner;
    logic [NS-1:0]     busy;
    logic [NS-1:0][7:0] slot;
    logic [NS-1:0][2:0] last;
    logic [NM-1:0]     gnt;
    logic [NM-1:0]     abort;
    logic [NM-1:0][31:0] rdata;
    logic [NS-1:0]     sel;
    logic [NS-1:0][31:0] saddr;
    logic [NS-1:0][1:0] ssize;
    logic [NS-1:0]     swr;
    logic [NS-1:0][31:0] swdata;
    logic [7:0]        cs_n;
  } state_type;
  state_type st_r;
  state_type st_nxt;
  logic [NM-1:0][2:0] dec_slave;
  logic [NM-1:0]      dec_ok;
  logic [NM-1:0][2:0] dec_cs;
  // ----------------------------------------
  // Per-master decoders
  // ----------------------------------------
  // master index is port
  genvar gm;
  generate
    for (gm = 0; gm < NM; gm++) begin : g_dec
      logic [3:0] area;
      logic [7:0] mb;
      assign area = M_ADDR_I[gm*32+28 +: 4];
      assign mb   = M_ADDR_I[gm*32+20 +: 8];
      always_comb begin
        dec_slave[gm] = S_SRAM;
        dec_ok[gm]    = 1'b0;
        dec_cs[gm]    = 3'h0;
        if (area == AREA_INT) begin
          if (mb == MB_BOOT) begin
            dec_ok[gm] = 1'b1;
            // boot layout for every master port, picked by its own remap bit
            if (st_r.remap[gm]) begin
              dec_slave[gm] = S_SRAM;
            end else if (st_r.boot_sel) begin
              dec_slave[gm] = S_ROM;
            end else begin
              dec_slave[gm] = S_EBI;
              dec_cs[gm]    = 3'h0;
            end
          end else if (mb == MB_ROM) begin
            dec_ok[gm]    = 1'b1;
            dec_slave[gm] = S_ROM;
          end else if (mb == MB_SRAM) begin
            dec_ok[gm]    = 1'b1;
            dec_slave[gm] = S_SRAM;
          end else if (mb == MB_USB || mb == MB_LCD) begin
            dec_ok[gm]    = 1'b1;
            dec_slave[gm] = S_HREG;
          end
        end else if (area >= AREA_EXT_LO && area <= AREA_EXT_HI) begin
          dec_ok[gm]    = 1'b1;
          dec_slave[gm] = S_EBI;
          dec_cs[gm]    = 3'(area - AREA_EXT_LO);
        end else if (area == AREA_PERI) begin
          dec_ok[gm]    = 1'b1;
          dec_slave[gm] = S_PERI;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Arbiters and data paths
  // ----------------------------------------
  // Grants are decided each cycle from the previous owner, so a master
  // sees its grant one cycle after the request; this keeps paths short.
  always_comb begin
    logic [2:0] cand;
    logic       found;
    logic [2:0] idx;
    cand  = 3'h0;
    found = 1'b0;
    idx   = 3'h0;
    st_nxt = st_r;
    st_nxt.gnt   = '0;
    st_nxt.abort = '0;
    st_nxt.cs_n  = 8'hff;
    st_nxt.remap = st_r.remap | REMAP_SET_I;
    for (int m = 0; m < NM; m++) begin
      if (M_REQ_I[m] && !dec_ok[m]) begin
        st_nxt.abort[m] = 1'b1;
      end
    end
    for (int s = 0; s < NS; s++) begin
      found = 1'b0;
      cand  = 3'h0;
      if (st_r.busy[s] && M_REQ_I[st_r.owner[s]] && dec_ok[st_r.owner[s]] &&
          dec_slave[st_r.owner[s]] == 3'(s) &&
          st_r.slot[s] < SLOT_LIMIT_I[s*8 +: 8]) begin
        found = 1'b1;
        cand  = st_r.owner[s];
      end else begin
        for (int k = 1; k <= NM; k++) begin
          idx = 3'((int'(st_r.last[s]) + k) % NM);
          if (!found && M_REQ_I[idx] && dec_ok[idx] && dec_slave[idx] == 3'(s)) begin
            found = 1'b1;
            cand  = idx;
          end
        end
      end
      st_nxt.busy[s] = found;
      st_nxt.sel[s]  = found;
      if (found) begin
        st_nxt.slot[s]  = (found && cand == st_r.owner[s] && st_r.busy[s]) ?
                          8'(st_r.slot[s] + 8'h01) : 8'h01;
        st_nxt.owner[s] = cand;
        st_nxt.last[s]  = cand;
        st_nxt.gnt[cand] = 1'b1;
        st_nxt.saddr[s]  = M_ADDR_I[cand*32 +: 32];
        st_nxt.ssize[s]  = M_SIZE_I[cand*2 +: 2];
        st_nxt.swr[s]    = M_WRITE_I[cand];
        st_nxt.swdata[s] = M_WDATA_I[cand*32 +: 32];
        if (3'(s) == S_EBI) begin
          st_nxt.cs_n[dec_cs[cand]] = 1'b0;
        end
      end else begin
        st_nxt.slot[s] = 8'h00;
        case (DEF_MODE_I[s*2 +: 2])
          DEF_NONE: st_nxt.owner[s] = st_r.owner[s];
          DEF_LAST: st_nxt.owner[s] = st_r.last[s];
          DEF_FIXED: st_nxt.owner[s] = DEF_MASTER_I[s*3 +: 3];
          default: st_nxt.owner[s] = st_r.owner[s];
        endcase
        st_nxt.last[s] = (DEF_MODE_I[s*2 +: 2] == DEF_FIXED) ?
                         DEF_MASTER_I[s*3 +: 3] : st_r.last[s];
      end
    end
    for (int m = 0; m < NM; m++) begin
      if (dec_ok[m]) begin
        st_nxt.rdata[m] = S_RDATA_I[32*int'(dec_slave[m]) +: 32];
      end
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      st_r <= '0;
      st_r.cs_n <= 8'hff;
      st_r.boot_sel <= BOOT_SELECT_PIN_I;
      st_r.remap <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign M_GNT_O   = st_r.gnt;
  assign M_ABORT_O = st_r.abort;
  assign M_RDATA_O = st_r.rdata;
  assign S_SEL_O   = st_r.sel;
  assign S_ADDR_O  = st_r.saddr;
  assign S_SIZE_O  = st_r.ssize;
  assign S_WRITE_O = st_r.swr;
  assign S_WDATA_O = st_r.swdata;
  assign EXT_CS_N_O = st_r.cs_n;
  // external boot runs slow with 16-bit bus
  assign BOOT_SLOW_CLK_O = ~st_r.boot_sel;
  assign BOOT_BUS16_O    = ~st_r.boot_sel;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_abort_no_sel: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I[0] && M_ADDR_I[31:28] == 4'ha) |=> M_ABORT_O[0] && !M_GNT_O[0])
    else $error("unused area not aborted");
  a_rom_base: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I[0] && M_ADDR_I[31:20] == 12'h004 && M_REQ_I[4:1] == 4'h0) |=> S_SEL_O[1])
    else $error("rom not selected at base");
  a_peri_area: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h01 && M_ADDR_I[31:28] == 4'hf) |=> S_SEL_O[4])
    else $error("peripheral area missed");
  a_ext_cs: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h01 && M_ADDR_I[31:28] == 4'h5) |=> !EXT_CS_N_O[4])
    else $error("chip select wrong");
  a_remap_sticky: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    st_r.remap[0] |=> st_r.remap[0])
    else $error("remap lost");
  a_boot_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ##1 $stable(st_r.boot_sel))
    else $error("boot select changed");
  a_one_gnt: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $countones(S_SEL_O) <= $countones(M_GNT_O))
    else $error("grant count mismatch");
  a_boot_rom: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h01 && M_ADDR_I[31:20] == 12'h000 && !st_r.remap[0] && st_r.boot_sel)
    |=> S_SEL_O[1])
    else $error("boot rom not at zero");
  a_remap_sram: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h01 && M_ADDR_I[31:20] == 12'h000 && st_r.remap[0]) |=> S_SEL_O[0])
    else $error("sram not at zero after remap");
  a_ext_boot: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h01 && M_ADDR_I[31:20] == 12'h000 && !st_r.remap[0] && !st_r.boot_sel)
    |=> !EXT_CS_N_O[0])
    else $error("external boot chip select missed");
  a_usb_regs: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h10 && M_ADDR_I[4*32+20 +: 12] == 12'h005) |=> S_SEL_O[2])
    else $error("usb host registers missed");
  a_lcd_regs: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h04 && M_ADDR_I[2*32+20 +: 12] == 12'h006) |=> S_SEL_O[2])
    else $error("display interface missed");
  a_abort_idle: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (M_REQ_I == 5'h02 && M_ADDR_I[32+28 +: 4] == 4'hb) |=> M_ABORT_O[1] && S_SEL_O == '0)
    else $error("slave selected on abort");
  a_remap_clear: assert property (@(posedge CLK_I)
    !RSTN_I |=> st_r.remap == '0)
    else $error("remap not cleared by reset");
  c_remap: cover property (@(posedge CLK_I) disable iff (!RSTN_I) REMAP_SET_I[0]);
  c_abort: cover property (@(posedge CLK_I) disable iff (!RSTN_I) M_ABORT_O[1]);
  c_contend: cover property (@(posedge CLK_I) disable iff (!RSTN_I) M_GNT_O[0] ##1 M_GNT_O[1]);
  c_slot_break: cover property (@(posedge CLK_I) disable iff (!RSTN_I) M_GNT_O[2] ##1 M_GNT_O[4]);
  c_ext_boot: cover property (@(posedge CLK_I) disable iff (!RSTN_I) !st_r.boot_sel && S_SEL_O[3]);
endmodule
`default_nettype wire

// file: hw/matrix_pkg.sv
// Constants shared by the bus matrix.
package matrix_pkg;
  // ----------------------------------------
  // Ports
  // ----------------------------------------
  localparam int NUM_MASTERS = 5;
  localparam int NUM_SLAVES  = 5;
  localparam int M_INSTR = 0;
  localparam int M_DATA  = 1;
  localparam int M_DMA   = 2;
  localparam int M_LCD   = 3;
  localparam int M_USB   = 4;
  localparam logic [2:0] S_SRAM = 3'h0;
  localparam logic [2:0] S_ROM  = 3'h1;
  localparam logic [2:0] S_HREG = 3'h2;
  localparam logic [2:0] S_EBI  = 3'h3;
  localparam logic [2:0] S_PERI = 3'h4;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [3:0]  AREA_INT    = 4'h0;
  localparam logic [3:0]  AREA_EXT_LO = 4'h1;
  localparam logic [3:0]  AREA_EXT_HI = 4'h8;
  localparam logic [3:0]  AREA_PERI   = 4'hf;
  localparam logic [7:0]  MB_BOOT     = 8'h00;
  localparam logic [7:0]  MB_ROM      = 8'h04;
  localparam logic [7:0]  MB_SRAM     = 8'h03;
  localparam logic [7:0]  MB_USB      = 8'h05;
  localparam logic [7:0]  MB_LCD      = 8'h06;
  // ----------------------------------------
  // Transfer sizes and arbitration
  // ----------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] DEF_NONE  = 2'h0;
  localparam logic [1:0] DEF_LAST  = 2'h1;
  localparam logic [1:0] DEF_FIXED = 2'h2;
  localparam logic [7:0] SLOT_RESET = 8'h10;
  localparam logic [4:0] SMC_BOOT_WIDTH_BITS = 5'h10;
endpackage

// file: verif/mem_slaves_model.sv
// Memory slave stand-ins that answer reads on the slave side of the matrix.
`timescale 1ns/1ps
`default_nettype none
module mem_slaves_model
  import matrix_pkg::*;
(
  // Read data of every slave
  output logic [NUM_SLAVES*32-1:0] rdata_o
);
  // word bus per slave.
  // Each value names its slave, so a wrong route shows up in the read data.
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      rdata_o[s*32 +: 32] = 32'hd000_0000 | 32'(s);
    end
  end
endmodule
`default_nettype wire

// file: verif/test_multi_master_bus_matrix_boot_remap.sv
// Self-checking bench for the bus matrix decode, arbitration and boot layout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module test_multi_master_bus_matrix_boot_remap
  import matrix_pkg::*;
;
  logic         clk, rstn, strap, slow, b16;
  logic [4:0]   remap, req, wr, gnt, abort, sel, swr, rmp_exp;
  logic [9:0]   mode, msize, ssize;
  logic [14:0]  defm;
  logic [39:0]  slot;
  logic [159:0] maddr, mwdata, mrdata, saddr, swdata, srdata;
  logic [7:0]   cs_n;
  logic         strap_exp;
  int           err_total, checked, cycles;

  bus_matrix bus_matrix_inst (.CLK_I(clk), .RSTN_I(rstn), .BOOT_SELECT_PIN_I(strap),
    .REMAP_SET_I(remap), .DEF_MODE_I(mode), .DEF_MASTER_I(defm), .SLOT_LIMIT_I(slot),
    .M_REQ_I(req), .M_ADDR_I(maddr), .M_SIZE_I(msize), .M_WRITE_I(wr), .M_WDATA_I(mwdata),
    .M_GNT_O(gnt), .M_ABORT_O(abort), .M_RDATA_O(mrdata), .S_SEL_O(sel), .S_ADDR_O(saddr),
    .S_SIZE_O(ssize), .S_WRITE_O(swr), .S_WDATA_O(swdata), .S_RDATA_I(srdata),
    .EXT_CS_N_O(cs_n), .BOOT_SLOW_CLK_O(slow), .BOOT_BUS16_O(b16));
  mem_slaves_model mem_slaves_model_inst (.rdata_o(srdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Reference map and bus cycle
  // ----------------------------------------
  function automatic logic [2:0] exp_dst(int m, logic [31:0] a);
    if (a[31:28] == AREA_INT) begin
      case (a[27:20])
        MB_BOOT: return rmp_exp[m] ? S_SRAM : (strap_exp ? S_ROM : S_EBI);
        MB_SRAM: return S_SRAM;
        MB_ROM:  return S_ROM;
        MB_USB:  return S_HREG;
        MB_LCD:  return S_HREG;
        default: return 3'h7;
      endcase
    end
    if (a[31:28] >= AREA_EXT_LO && a[31:28] <= AREA_EXT_HI) return S_EBI;
    if (a[31:28] == AREA_PERI) return S_PERI;
    return 3'h7;
  endfunction

  task automatic do_reset(logic s);
    strap     <= s;
    strap_exp = s;
    rmp_exp   = 5'h00;
    rstn      <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(cs_n, 8'hff)
    `CHK(gnt, 5'h00)
    `CHK({slow, b16}, {2{~s}})
    @(posedge clk);
  endtask

  task automatic acc(int m, logic [31:0] a, logic [1:0] sz, logic w);
    logic [2:0] d;
    logic [7:0] cs;
    d  = exp_dst(m, a);
    cs = 8'hff;
    if (d == S_EBI) cs[(a[31:28] == 4'h0) ? 0 : int'(a[31:28]) - 1] = 1'b0;
    req[m]              <= 1'b1;
    maddr[m*32 +: 32]   <= a;
    msize[m*2 +: 2]     <= sz;
    wr[m]               <= w;
    mwdata[m*32 +: 32]  <= ~a;
    @(posedge clk);
    req[m] <= 1'b0;
    #1;
    `CHK(abort[m], d == 3'h7)
    `CHK(gnt[m], d != 3'h7)
    `CHK(sel, (d == 3'h7) ? 5'h00 : 5'h01 << d)
    `CHK(cs_n, cs)
    if (d != 3'h7) begin
      `CHK(saddr[d*32 +: 32], a)
      `CHK({ssize[d*2 +: 2], swr[d]}, {sz, w})
      `CHK(swdata[d*32 +: 32], ~a)
      `CHK(mrdata[m*32 +: 32], 32'hd000_0000 | 32'(d))
    end
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_map();
    // areas 1 to 15 once each, the master rotating through all five.
    for (int t = 1; t < 16; t++) acc(t % 5, {t[3:0], 28'h0123456}, 2'(t % 3), t[0]);
    acc(2, 32'h0030_0010, SIZE_WORD, 1'b0);
    acc(3, 32'h0040_0004, SIZE_HALF, 1'b0);
    acc(4, 32'h0050_0008, SIZE_BYTE, 1'b1);
    acc(2, 32'h0060_000c, SIZE_WORD, 1'b1);
    acc(0, 32'h000f_fffc, SIZE_WORD, 1'b0);
    acc(1, 32'h0070_0000, SIZE_WORD, 1'b0);
    $display("test map done");
  endtask

  task automatic t_boot();
    remap <= 5'h01;
    @(posedge clk);
    remap   <= 5'h00;
    rmp_exp = 5'h01;
    @(posedge clk);
    acc(0, 32'h0000_0000, SIZE_WORD, 1'b0);
    acc(1, 32'h0000_0000, SIZE_WORD, 1'b0);
    acc(0, 32'h0040_0000, SIZE_WORD, 1'b0);
    do_reset(1'b0);
    acc(0, 32'h0000_0000, SIZE_HALF, 1'b0);
    strap <= 1'b1;
    acc(1, 32'h0000_0002, SIZE_HALF, 1'b1);
    $display("test boot done");
  endtask

  task automatic t_arb();
    int  g2, g3, g4;
    logic both;
    for (int md = 0; md < 3; md++) begin
      g2 = 0;
      g3 = 0;
      g4 = 0;
      both = 1'b0;
      mode  <= {8'h00, 2'(md)};
      defm  <= 15'h0003;
      slot  <= {32'hffff_ffff, 8'h02};
      maddr <= {32'h0030_0000, 32'h0040_0000, 32'h0030_0004, 64'h0};
      req   <= 5'h1c;
      repeat (24) begin
        @(posedge clk);
        #1;
        g2 += int'(gnt[2]);
        g3 += int'(gnt[3]);
        g4 += int'(gnt[4]);
        both |= gnt[2] & gnt[4];
      end
      @(posedge clk);
      req <= 5'h00;
      `CHK(both, 1'b0)
      `CHK(g2 >= 6 && g4 >= 6, 1'b1)
      `CHK(g3, 24)
      @(posedge clk);
    end
    $display("test arbitration done");
  endtask

  initial begin
    {rstn, remap, req, wr, mode, msize, defm, slot, maddr, mwdata} = '0;
    strap = 1'b1;
    do_reset(1'b1);
    t_map();
    t_boot();
    do_reset(1'b1);
    t_arb();
    stop_test();
  end
endmodule
`default_nettype wire
